// File: rtl/fpes_sequencer.sv
// Purpose: flash unlock, program and page-erase sequencer
// Assumes: control and page-select writes and memory writes are one-cycle strobes
// Notes: erase is walked byte by byte through the array port after the busy time
`timescale 1ns/100ps
module fpes_sequencer #(
  parameter logic [7:0] SECTOR_PROTECT_DEFAULT = 8'h00,
  parameter int PROG_TIME = fpes_pkg::PROG_CYCLES,
  parameter int ERASE_TIME = fpes_pkg::ERASE_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // control register writes from the processor
  input wire logic ctrl_we_in,
  input wire logic [7:0] ctrl_data_in,
  input wire logic page_we_in,
  input wire logic [fpes_pkg::PAGE_W-1:0] page_data_in,
  // sector protection, one bit per sector
  input wire logic [7:0] sector_protect_in,
  // program-memory write from the processor
  input wire fpes_pkg::fpes_mem_req_t mem_req_in,
  // interrupt requests from peripherals
  input wire logic irq_in,
  // processor control
  output logic cpu_stall_out,
  output logic irq_out,
  // flash array port
  output fpes_pkg::fpes_array_cmd_t array_cmd_out,
  // status
  output logic unlocked_out,
  output logic busy_out,
  output logic [fpes_pkg::PAGE_W-1:0] page_out
);
  typedef enum logic [2:0] {
    FPES_LOCKED,
    FPES_GOT_RESET,
    FPES_GOT_PAGE,
    FPES_GOT_KEY1,
    FPES_GOT_KEY2,
    FPES_UNLOCKED,
    FPES_PROGRAM,
    FPES_ERASE
  } fpes_state_t;

  localparam logic [fpes_pkg::TIMER_W-1:0] PROG_LOAD = fpes_pkg::TIMER_W'(PROG_TIME);
  localparam logic [fpes_pkg::TIMER_W-1:0] ERASE_LOAD = fpes_pkg::TIMER_W'(ERASE_TIME);

  fpes_state_t state_reg;
  fpes_state_t state_next;
  logic [fpes_pkg::PAGE_W-1:0] page_reg;
  logic [fpes_pkg::OFFS_W-1:0] erase_offs_reg;
  logic erase_walk_reg;
  logic irq_pend_reg;
  logic [7:0] protect_reg;
  logic protect_loaded_reg;
  fpes_pkg::fpes_array_cmd_t cmd_reg;
  logic timer_start;
  logic [fpes_pkg::TIMER_W-1:0] timer_load;
  logic timer_busy;
  logic timer_done;
  logic page_protected;
  logic write_in_page;

  function automatic logic page_is_protected(input logic [fpes_pkg::PAGE_W-1:0] pg,
                                             input logic [7:0] prot);
    logic [fpes_pkg::SECTOR_W-1:0] sec;
    sec = pg[fpes_pkg::PAGE_W-1 -: fpes_pkg::SECTOR_W];
    return prot[sec];
  endfunction

  fpes_timer #(
    .WIDTH(fpes_pkg::TIMER_W)
  ) i_fpes_timer (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(timer_start),
    .load_in(timer_load),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // protection is sampled after reset release, never under reset
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      protect_reg <= SECTOR_PROTECT_DEFAULT;
      protect_loaded_reg <= 1'b0;
    end
    else
    begin
      protect_reg <= sector_protect_in;
      protect_loaded_reg <= 1'b1;
    end
  end

  assign page_protected = !protect_loaded_reg || page_is_protected(page_reg, protect_reg);
  assign write_in_page = mem_req_in.addr[fpes_pkg::ADDR_W-1:fpes_pkg::OFFS_W] == page_reg;

  always_comb
  begin
    state_next = state_reg;
    timer_start = 1'b0;
    timer_load = PROG_LOAD;
    case (state_reg)
      FPES_LOCKED:
      begin
        if (ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_RESET)
          state_next = FPES_GOT_RESET;
      end
      FPES_GOT_RESET:
      begin
        if (ctrl_we_in)
          state_next = (ctrl_data_in == fpes_pkg::CMD_RESET) ? FPES_GOT_RESET : FPES_LOCKED;
        else if (page_we_in)
          state_next = FPES_GOT_PAGE;
      end
      FPES_GOT_PAGE:
      begin
        if (ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_UNLOCK1)
          state_next = FPES_GOT_KEY1;
        else if (ctrl_we_in)
          state_next = (ctrl_data_in == fpes_pkg::CMD_RESET) ? FPES_GOT_RESET : FPES_LOCKED;
        else if (page_we_in)
          state_next = FPES_GOT_PAGE;
      end
      FPES_GOT_KEY1:
      begin
        if (ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_UNLOCK2)
          state_next = FPES_GOT_KEY2;
        else if (ctrl_we_in)
          state_next = (ctrl_data_in == fpes_pkg::CMD_RESET) ? FPES_GOT_RESET : FPES_LOCKED;
        else if (page_we_in)
          state_next = FPES_LOCKED;
      end
      FPES_GOT_KEY2:
      begin
        if (page_we_in)
          state_next = (page_data_in == page_reg) ? FPES_UNLOCKED : FPES_LOCKED;
        else if (ctrl_we_in)
          state_next = (ctrl_data_in == fpes_pkg::CMD_RESET) ? FPES_GOT_RESET : FPES_LOCKED;
      end
      FPES_UNLOCKED:
      begin
        if (ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_RESET)
          state_next = FPES_GOT_RESET;
        else if (ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_ERASE)
        begin
          // protected page: erase refused and the controller relocks
          if (page_protected)
            state_next = FPES_LOCKED;
          else
          begin
            state_next = FPES_ERASE;
            timer_start = 1'b1;
            timer_load = ERASE_LOAD;
          end
        end
        else if (ctrl_we_in || page_we_in)
          state_next = FPES_LOCKED;
        else if (mem_req_in.we && write_in_page && !page_protected)
        begin
          state_next = FPES_PROGRAM;
          timer_start = 1'b1;
        end
      end
      FPES_PROGRAM:
      begin
        if (timer_done)
          state_next = FPES_UNLOCKED;
      end
      FPES_ERASE:
      begin
        if (erase_walk_reg && erase_offs_reg == fpes_pkg::OFFS_W'(fpes_pkg::PAGE_BYTES - 1))
          state_next = FPES_LOCKED;
      end
      default:
        state_next = FPES_LOCKED;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      state_reg <= FPES_LOCKED;
    else
      state_reg <= state_next;
  end

  // page select is frozen while an operation runs
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      page_reg <= '0;
    else if (page_we_in && state_reg != FPES_PROGRAM && state_reg != FPES_ERASE)
      page_reg <= page_data_in;
  end

  // erase walk starts once the busy time has elapsed
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      erase_walk_reg <= 1'b0;
      erase_offs_reg <= '0;
    end
    else if (state_reg != FPES_ERASE)
    begin
      erase_walk_reg <= 1'b0;
      erase_offs_reg <= '0;
    end
    else if (timer_done)
      erase_walk_reg <= 1'b1;
    else if (erase_walk_reg)
      erase_offs_reg <= erase_offs_reg + fpes_pkg::OFFS_W'(1);
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      cmd_reg <= '0;
    else if (state_reg == FPES_UNLOCKED && state_next == FPES_PROGRAM)
    begin
      cmd_reg.we <= 1'b1;
      cmd_reg.erase <= 1'b0;
      cmd_reg.addr <= mem_req_in.addr;
      cmd_reg.data <= mem_req_in.data;
    end
    else if (state_reg == FPES_ERASE && erase_walk_reg)
    begin
      cmd_reg.we <= 1'b1;
      cmd_reg.erase <= 1'b1;
      cmd_reg.addr <= {page_reg, erase_offs_reg};
      cmd_reg.data <= fpes_pkg::ERASED_BYTE;
    end
    else
      cmd_reg <= '0;
  end

  // a request arriving in the release cycle is kept pending, not lost
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      irq_pend_reg <= 1'b0;
    else if (irq_in && cpu_stall_out)
      irq_pend_reg <= 1'b1;
    else if (!cpu_stall_out)
      irq_pend_reg <= 1'b0;
  end

  assign cpu_stall_out = state_reg == FPES_PROGRAM || state_reg == FPES_ERASE;
  assign irq_out = !cpu_stall_out && (irq_in || irq_pend_reg);
  assign array_cmd_out = cmd_reg;
  assign unlocked_out = state_reg == FPES_UNLOCKED;
  assign busy_out = cpu_stall_out || timer_busy;
  assign page_out = page_reg;
endmodule

// File: inc/fpes_pkg.sv
// Purpose: constants and carrier types for the flash program/erase sequencer
// Assumes: one system clock, synchronous active-high reset
// Notes: page size and command codes for the sequencer, timer width for its timer
package fpes_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_W = 7;
  localparam int PAGE_BYTES = 512;
  localparam int OFFS_W = 9;
  localparam int SECTOR_W = 3;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CMD_ERASE = 8'h95;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PROG_CYCLES = 4;
  localparam int ERASE_CYCLES = 16;
  localparam int TIMER_W = 16;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fpes_mem_req_t;

  typedef struct packed {
    logic we;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fpes_array_cmd_t;
endpackage

// File: rtl/fpes_timer.sv
// Purpose: busy-time counter for one flash operation
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses once when the load count has elapsed
`timescale 1ns/100ps
module fpes_timer #(
  parameter int WIDTH = fpes_pkg::TIMER_W
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // control
  input wire logic start_in,
  input wire logic [WIDTH-1:0] load_in,
  // status
  output logic busy_out,
  output logic done_out
);
  logic [WIDTH-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start_in && !busy_reg)
      begin
        count_reg <= load_in;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (count_reg <= WIDTH'(1))
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg - WIDTH'(1);
        end
      end
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;
endmodule

// File: verification/fpes_sequencer_properties.sv
// Purpose: port checker for the flash sequencer
// Assumes: timing as handed over with the design
// Notes: bound from the testbench top file
`timescale 1ns/100ps
module fpes_seq_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // processor side
  input wire logic ctrl_we_in,
  input wire logic [7:0] ctrl_data_in,
  input wire logic page_we_in,
  input wire logic [fpes_pkg::PAGE_W-1:0] page_data_in,
  input wire logic [7:0] sector_protect_in,
  input wire fpes_pkg::fpes_mem_req_t mem_req_in,
  input wire logic irq_in,
  // outputs watched
  input wire logic cpu_stall_out,
  input wire logic irq_out,
  input wire fpes_pkg::fpes_array_cmd_t array_cmd_out,
  input wire logic unlocked_out,
  input wire logic [fpes_pkg::PAGE_W-1:0] page_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic hit;
  logic prot;
  logic [8:0] offs;
  assign hit = mem_req_in.we && unlocked_out && mem_req_in.addr[15:9] == page_out;
  assign prot = sector_protect_in[page_out[6:4]];
  assign offs = array_cmd_out.addr[8:0];
  property p_relock;
    ctrl_we_in && ctrl_data_in == 8'h00 && !cpu_stall_out |=> !unlocked_out;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_prog;
    hit && !prot && !cpu_stall_out |=> cpu_stall_out && array_cmd_out.we
      && array_cmd_out.addr == $past(mem_req_in.addr);
  endproperty
  a_prog: assert property (p_prog) else $error("write not programmed");
  property p_refuse;
    mem_req_in.we && (!hit || prot) && !cpu_stall_out
      |=> !(array_cmd_out.we && !array_cmd_out.erase);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write not ignored");
  property p_stall_len;
    $rose(cpu_stall_out) && array_cmd_out.we && !array_cmd_out.erase
      |-> cpu_stall_out [*5] ##1 !cpu_stall_out;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length");
  property p_irq_mask;
    cpu_stall_out |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while stalled");
  property p_irq_late;
    $fell(cpu_stall_out) && $past(irq_in) |-> irq_out;
  endproperty
  a_irq_late: assert property (p_irq_late) else $error("irq lost");
  property p_erase_byte;
    array_cmd_out.erase |-> array_cmd_out.we && array_cmd_out.data == 8'hFF
      && array_cmd_out.addr[15:9] == page_out;
  endproperty
  a_erase_byte: assert property (p_erase_byte) else $error("erase byte");
  property p_erase_step;
    array_cmd_out.erase && $past(array_cmd_out.erase) |-> offs == $past(offs) + 9'h001;
  endproperty
  a_erase_step: assert property (p_erase_step) else $error("erase step");
  property p_erase_end;
    $fell(array_cmd_out.erase) |-> ##[0:2] (!cpu_stall_out && !unlocked_out);
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("no lock after erase");
  property p_erase_prot;
    ctrl_we_in && ctrl_data_in == fpes_pkg::CMD_ERASE && unlocked_out && prot
      && !cpu_stall_out |=> !unlocked_out && !cpu_stall_out;
  endproperty
  a_erase_prot: assert property (p_erase_prot) else $error("protected erase");
  property p_unlock;
    $rose(unlocked_out) && !$past(cpu_stall_out)
      |-> $past(page_we_in) && $past(page_data_in) == page_out;
  endproperty
  a_unlock: assert property (p_unlock) else $error("bad unlock");
  c_prog: cover property (hit && !prot);
  c_erase: cover property ($fell(array_cmd_out.erase));
  c_irq: cover property ($fell(cpu_stall_out) && irq_out);
endmodule

// File: verification/fpes_flash_model.sv
// Purpose: behavioural flash array behind the sequencer
// Assumes: one byte command per clock
// Notes: cells start at A5 so that an erase shows
`timescale 1ns/100ps
module fpes_flash_model (
  // clock
  input wire logic clock_in,
  // array commands
  input wire fpes_pkg::fpes_array_cmd_t array_cmd_in
);
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'hA5;
  end
  // programming only clears bits, as a real cell does
  always @(posedge clock_in)
  begin
    if (array_cmd_in.we && array_cmd_in.erase)
      mem[array_cmd_in.addr] <= 8'hFF;
    else if (array_cmd_in.we)
      mem[array_cmd_in.addr] <= mem[array_cmd_in.addr] & array_cmd_in.data;
  end
endmodule

// File: verification/flash_program_erase_sequencer_tb.sv
// Purpose: self-checking bench for the flash sequencer
// Assumes: strobes driven at rising edges, sampled at falling edges
// Notes: every location is programmed once only
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module flash_program_erase_sequencer_tb;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ctrl_we_in = 1'b0;
  logic page_we_in = 1'b0;
  logic irq_in = 1'b0;
  logic [7:0] ctrl_data_in = 8'h00;
  logic [7:0] sector_protect_in = 8'h00;
  logic [fpes_pkg::PAGE_W-1:0] page_data_in = 7'h00;
  fpes_pkg::fpes_mem_req_t mem_req_in = '0;
  logic cpu_stall_out, irq_out, unlocked_out, busy_out;
  logic [fpes_pkg::PAGE_W-1:0] page_out;
  fpes_pkg::fpes_array_cmd_t array_cmd_out;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  fpes_sequencer i_fpes_sequencer (.clock_in, .sys_rst_in, .ctrl_we_in, .ctrl_data_in,
    .page_we_in, .page_data_in, .sector_protect_in, .mem_req_in, .irq_in, .cpu_stall_out,
    .irq_out, .array_cmd_out, .unlocked_out, .busy_out, .page_out);
  fpes_flash_model i_fpes_flash_model (.clock_in(clock_in), .array_cmd_in(array_cmd_out));
  initial
  begin
    forever #25 clock_in = ~clock_in;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      final_report;
    end
  end
  task automatic ctrl(input logic [7:0] d);
    @(posedge clock_in);
    ctrl_we_in <= 1'b1;
    ctrl_data_in <= d;
    @(posedge clock_in);
    ctrl_we_in <= 1'b0;
  endtask
  task automatic pg(input logic [6:0] p);
    @(posedge clock_in);
    page_we_in <= 1'b1;
    page_data_in <= p;
    @(posedge clock_in);
    page_we_in <= 1'b0;
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    mem_req_in <= '{1'b1, a, d};
    @(posedge clock_in);
    mem_req_in.we <= 1'b0;
  endtask
  task automatic unlock(input logic [6:0] p);
    ctrl(8'h00);
    pg(p);
    ctrl(8'h73);
    ctrl(8'h8C);
    pg(p);
    @(negedge clock_in);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clock_in);
    while (cpu_stall_out !== 1'b0 && n < 2000)
    begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 2000)
      errors++;
  endtask
  task automatic t_bad_order;
    ctrl(8'h00);
    pg(7'h02);
    ctrl(8'h8C);
    ctrl(8'h73);
    pg(7'h02);
    @(negedge clock_in);
    `CHK(unlocked_out, 1'b0);
    ctrl(8'h00);
    pg(7'h02);
    ctrl(8'h73);
    ctrl(8'h8C);
    pg(7'h05);
    @(negedge clock_in);
    `CHK(unlocked_out, 1'b0);
    $display("bad unlock order done");
  endtask
  task automatic t_erase;
    unlock(7'h03);
    `CHK(unlocked_out, 1'b1);
    ctrl(fpes_pkg::CMD_ERASE);
    @(negedge clock_in);
    `CHK(cpu_stall_out, 1'b1);
    `CHK(busy_out, 1'b1);
    `CHK(page_out, 7'h03);
    @(posedge clock_in);
    irq_in <= 1'b1;
    @(posedge clock_in);
    irq_in <= 1'b0;
    wait_idle;
    `CHK(irq_out, 1'b1);
    `CHK(unlocked_out, 1'b0);
    // the last erased byte lands in the array one edge after the stall drops
    @(negedge clock_in);
    for (int i = 0; i < 512; i++)
      `CHK(i_fpes_flash_model.mem[16'h0600 + i], 8'hFF);
    `CHK(i_fpes_flash_model.mem[16'h0800], 8'hA5);
    $display("page erase done");
  endtask
  task automatic t_prog;
    unlock(7'h03);
    mw(16'h0610, 8'h5A);
    @(negedge clock_in);
    `CHK(cpu_stall_out, 1'b1);
    // request held to the last stalled edge, then dropped: only the pending latch remains
    @(posedge clock_in);
    irq_in <= 1'b1;
    repeat (fpes_pkg::PROG_CYCLES) @(posedge clock_in);
    irq_in <= 1'b0;
    wait_idle;
    `CHK(irq_out, 1'b1);
    mw(16'h0810, 8'h3C);
    @(negedge clock_in);
    `CHK(cpu_stall_out, 1'b0);
    ctrl(8'h00);
    @(negedge clock_in);
    `CHK(unlocked_out, 1'b0);
    mw(16'h0611, 8'h00);
    repeat (8) @(negedge clock_in);
    `CHK(i_fpes_flash_model.mem[16'h0610], 8'h5A);
    `CHK(i_fpes_flash_model.mem[16'h0810], 8'hA5);
    `CHK(i_fpes_flash_model.mem[16'h0611], 8'hFF);
    $display("program done");
  endtask
  task automatic t_protect;
    @(posedge clock_in);
    sector_protect_in <= 8'h01;
    unlock(7'h03);
    mw(16'h0620, 8'h00);
    @(negedge clock_in);
    `CHK(cpu_stall_out, 1'b0);
    ctrl(fpes_pkg::CMD_ERASE);
    @(negedge clock_in);
    `CHK(cpu_stall_out, 1'b0);
    `CHK(unlocked_out, 1'b0);
    repeat (8) @(negedge clock_in);
    `CHK(i_fpes_flash_model.mem[16'h0620], 8'hFF);
    `CHK(i_fpes_flash_model.mem[16'h0610], 8'h5A);
    @(posedge clock_in);
    sector_protect_in <= 8'h00;
    $display("protected sector done");
  endtask
  initial
  begin
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    t_bad_order;
    t_erase;
    t_prog;
    t_protect;
    final_report;
  end
endmodule
bind fpes_sequencer fpes_seq_props i_fpes_seq_props (.clock_in, .sys_rst_in, .ctrl_we_in,
  .ctrl_data_in, .page_we_in, .page_data_in, .sector_protect_in, .mem_req_in, .irq_in,
  .cpu_stall_out, .irq_out, .array_cmd_out, .unlocked_out, .page_out);
